// ---- design/pin_sync.v ----
// Purpose: Two-flop synchroniser for a group of pin inputs.
// Assumes: Inputs are asynchronous to pclk; all bits share one stage count.
// Notes:   First stage is read by the second stage only.
`timescale 1ns/10ps
module pin_sync #(
	parameter WIDTH = 1
) (
	input  wire             pclk,
	input  wire             presetn,
	input  wire [WIDTH-1:0] async_in,
	input  wire [WIDTH-1:0] reset_val,
	output wire [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	// Reset value loads on the first edge after release; the flops reset to zero
	reg             armed_q;

	////////////////////////////////////////////////////////////////////////
	// Two stages; until armed, the pin's idle level is forced so no false edge appears
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q  <= {WIDTH{1'b0}};
			sync_q  <= {WIDTH{1'b0}};
			armed_q <= 1'b0;
		end else begin
			armed_q <= 1'b1;
			meta_q  <= async_in;
			sync_q  <= armed_q ? meta_q : reset_val;
		end
	end

	assign sync_out = armed_q ? sync_q : reset_val;

endmodule

// ---- design/sar_adc_conversion_sequencer.v ----
// Contract
// - Write strobe rising with chip select low starts tracking.
// - External acquisition: the next qualified write rising edge switches to hold; here only if that byte has D5 zero, else tracking restarts.
// - Internal acquisition: hold on fourth falling conversion clock edge after write.
// - Every conversion lasts 13 conversion clock cycles.
// - A control byte written during conversion aborts it and restarts acquisition.
// - Acquisition mode bit decides: internally timed hold, or hold on a second write.
// - Two acquisition timing options, chosen by one control bit.
// - Single-ended: addressed channel to positive input, negative to common.
// - Pseudo-differential: fixed channel pair from address, positive side sampled.
// - Result is 10 bits, read as low eight plus high two.
// - Done flag low when ready; high on first read or new control byte.
// - Upper byte select high gives two MSBs, low gives eight LSBs.
// - Bit D5 zero internal acquisition, one external acquisition.
// - Bits D7..D6: full down, standby, normal internal clock, normal external clock.
//
// Purpose: Sequences track/hold and SAR conversion behind a byte-wide host port.
// Assumes: Pins are asynchronous and pass pin_sync; comparator output is a pin.
// Notes:   APB side adds status, mask and interrupt; conversion clock is an enable.
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/10ps
`include "sar_seq_map.vh"
module sar_adc_conversion_sequencer #(
	parameter INT_CLK_CYC = `INT_CLK_CYC
) (
	input  wire        pclk,
	input  wire        presetn,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	output wire        irq,
	// Host parallel port pins
	input  wire        cs_n,
	input  wire        wr_n,
	input  wire        rd_n,
	input  wire        upper_byte_select,
	input  wire [7:0]  data_in,
	output reg  [7:0]  data_out,
	output wire        data_oe,
	output reg         done_n_out,
	output wire        done_n_oe,
	input  wire        ext_conv_clk,
	// Analog front end control
	input  wire        comparator_high,
	output reg         track,
	output reg  [9:0]  dac_code,
	output reg  [2:0]  mux_pos_sel,
	output reg  [2:0]  mux_neg_sel,
	output reg         neg_to_common,
	output reg         input_polarity_select,
	output reg  [1:0]  power_state_field
);

	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_ACQI = 4'h2;
	localparam [3:0] ST_ACQE = 4'h4;
	localparam [3:0] ST_CONV = 4'h8;

	// Pseudo-differential partner: flip the lowest address bit within the pair
	function [2:0] pair_mate;
		input [2:0] addr;
		begin
			pair_mate = {addr[2:1], ~addr[0]};
		end
	endfunction

	// Rising or falling edge of a synchronised level
	function edge_seen;
		input now_v;
		input prev_v;
		input rising;
		begin
			edge_seen = rising ? (now_v & ~prev_v) : (~now_v & prev_v);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers, all of one depth so strobe and data stay aligned
	wire [14:0] pins_s;
	pin_sync #(
		.WIDTH(15)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({comparator_high, ext_conv_clk, upper_byte_select, rd_n, wr_n, cs_n,
		            data_in, 1'b0}),
		.reset_val({1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 8'h00, 1'b0}),
		.sync_out (pins_s)
	);

	wire       cs_s   = ~pins_s[9];
	wire       wr_s   = pins_s[10];
	wire       rd_s   = pins_s[11];
	wire       ubs_s  = pins_s[12];
	wire       eclk_s = pins_s[13];
	wire       comp_s = pins_s[14];
	wire [7:0] din_s  = pins_s[8:1];

	reg        wr_prev_q;
	reg        rd_prev_q;
	reg        eclk_prev_q;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_prev_q   <= 1'b1;
			rd_prev_q   <= 1'b1;
			eclk_prev_q <= 1'b0;
		end else begin
			wr_prev_q   <= wr_s;
			rd_prev_q   <= rd_s;
			eclk_prev_q <= eclk_s;
		end
	end

	// Qualified strobes; the chip select must be low at the strobe edge
	wire wr_evt = cs_s & edge_seen(wr_s, wr_prev_q, 1'b1);
	wire rd_evt = cs_s & edge_seen(rd_s, rd_prev_q, 1'b0);

	////////////////////////////////////////////////////////////////////////
	// Internal conversion clock: a divider makes rise and fall enables
	reg [15:0] div_q;
	reg        clk_ext_q;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 16'h0000;
		end else if (div_q == INT_CLK_CYC[15:0] - 16'h0001) begin
			div_q <= 16'h0000;
		end else begin
			div_q <= div_q + 16'h0001;
		end
	end

	wire int_rise = (div_q == 16'h0000);
	wire int_fall = (div_q == INT_CLK_CYC[15:1]);
	// Clock source follows the last normal-operation setting
	wire cclk_rise = clk_ext_q ? edge_seen(eclk_s, eclk_prev_q, 1'b1) : int_rise;
	wire cclk_fall = clk_ext_q ? edge_seen(eclk_s, eclk_prev_q, 1'b0) : int_fall;

	////////////////////////////////////////////////////////////////////////
	// Control byte decode
	reg  [7:0] ctrl_q;
	wire       acq_ext_w = din_s[`CTRL_ACQ_BIT];
	wire [1:0] pd_w      = din_s[`CTRL_PD_HI:`CTRL_PD_LO];

	////////////////////////////////////////////////////////////////////////
	// Sequencer state machine
	reg [3:0] state_q;
	reg [2:0] acq_cnt_q;
	reg [3:0] conv_cnt_q;
	reg [9:0] result_q;
	reg       done_evt;
	reg       abort_evt;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q    <= ST_IDLE;
			ctrl_q     <= `CTRL_RESET;
			clk_ext_q  <= 1'b0;
			track      <= 1'b0;
			acq_cnt_q  <= 3'h0;
			conv_cnt_q <= 4'h0;
			dac_code   <= 10'h000;
			result_q   <= 10'h000;
			done_evt   <= 1'b0;
			abort_evt  <= 1'b0;
		end else begin
			done_evt  <= 1'b0;
			abort_evt <= 1'b0;
			if (wr_evt) begin
				ctrl_q <= din_s;
				// Clock mode is untouched by the power-down settings
				if (pd_w[1]) begin
					clk_ext_q <= pd_w[0];
				end
				acq_cnt_q  <= 3'h0;
				conv_cnt_q <= 4'h0;
				dac_code   <= 10'h000;
				if (state_q == ST_CONV) begin
					abort_evt <= 1'b1;
				end
				if (state_q == ST_ACQE && !acq_ext_w) begin
					// Second write ends acquisition and starts conversion
					track   <= 1'b0;
					state_q <= ST_CONV;
				end else begin
					track   <= 1'b1;
					state_q <= acq_ext_w ? ST_ACQE : ST_ACQI;
				end
			end else begin
				case (state_q)
				ST_ACQI: begin
					if (cclk_fall) begin
						acq_cnt_q <= acq_cnt_q + 3'h1;
						if (acq_cnt_q == `ACQ_FALL_EDGES - 1) begin
							track   <= 1'b0;
							state_q <= ST_CONV;
						end
					end
				end
				ST_ACQE: begin
					// Acquisition of indeterminate length; only a write ends it
					track <= 1'b1;
				end
				ST_CONV: begin
					if (cclk_rise) begin
						conv_cnt_q <= conv_cnt_q + 4'h1;
						if (conv_cnt_q == 4'h0) begin
							dac_code[9] <= 1'b1;
						end else if (conv_cnt_q <= `RESULT_BITS) begin
							// Resolve one bit, then try the next lower one
							dac_code[4'd10 - conv_cnt_q] <= comp_s;
							if (conv_cnt_q < `RESULT_BITS) begin
								dac_code[4'd9 - conv_cnt_q] <= 1'b1;
							end
						end else if (conv_cnt_q == `CONV_CYCLES - 1) begin
							result_q <= dac_code;
							done_evt <= 1'b1;
							state_q  <= ST_IDLE;
						end
					end
				end
				ST_IDLE: begin
					track <= 1'b0;
				end
				default: begin
					state_q <= ST_IDLE;
					track   <= 1'b0;
				end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Input multiplexer and mode outputs from the latched control byte
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mux_pos_sel           <= 3'h0;
			mux_neg_sel           <= 3'h0;
			neg_to_common         <= 1'b1;
			input_polarity_select <= 1'b0;
			power_state_field     <= `PWR_FULL_DOWN;
		end else begin
			mux_pos_sel           <= ctrl_q[`CTRL_ADDR_HI:`CTRL_ADDR_LO];
			input_polarity_select <= ctrl_q[`CTRL_UNI_BIT];
			power_state_field     <= ctrl_q[`CTRL_PD_HI:`CTRL_PD_LO];
			if (ctrl_q[`CTRL_SGL_BIT]) begin
				neg_to_common <= 1'b1;
				mux_neg_sel   <= 3'h0;
			end else begin
				neg_to_common <= 1'b0;
				mux_neg_sel   <= pair_mate(ctrl_q[`CTRL_ADDR_HI:`CTRL_ADDR_LO]);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Done flag pin: low when a result is ready; a read or a new byte releases it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_n_out <= 1'b1;
		end else if (done_evt) begin
			done_n_out <= 1'b0;
		end else if (rd_evt || wr_evt) begin
			done_n_out <= 1'b1;
		end
	end

	// Outputs float whenever the chip is not selected
	assign done_n_oe = cs_s;
	assign data_oe   = cs_s & ~rd_s;

	// Read data: two MSBs or eight LSBs, steered by the upper byte select
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_out <= 8'h00;
		end else if (ubs_s) begin
			data_out <= {6'h00, result_q[9:8]};
		end else begin
			data_out <= result_q[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait states, error on unmapped offsets
	reg  [`ST_WIDTH-1:0] status_q;
	reg  [`ST_WIDTH-1:0] mask_q;
	wire                 apb_acc = psel & penable;
	wire                 mapped  = (paddr == `REG_STATUS) || (paddr == `REG_MASK) ||
	                               (paddr == `REG_STATE)  || (paddr == `REG_CTRL);
	wire                 st_rd   = apb_acc & ~pwrite & (paddr == `REG_STATUS);
	wire [`ST_WIDTH-1:0] st_set  = {wr_evt, abort_evt, done_evt};

	assign pready  = 1'b1;
	assign pslverr = apb_acc & ~mapped;
	assign irq     = |(status_q & mask_q);

	// Sticky events; a read clears, but an event in that cycle still lands
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_q <= {`ST_WIDTH{1'b0}};
			mask_q   <= `MASK_RESET;
		end else begin
			status_q <= (st_rd ? {`ST_WIDTH{1'b0}} : status_q) | st_set;
			if (apb_acc && pwrite && paddr == `REG_MASK) begin
				mask_q <= pwdata[`ST_WIDTH-1:0];
			end
		end
	end

	// Read mux, combinational so data is valid in the access phase
	always @* begin
		prdata = 32'h00000000;
		if (psel && !pwrite) begin
			case (paddr)
			`REG_STATUS: prdata = {29'h0, status_q};
			`REG_MASK:   prdata = {29'h0, mask_q};
			`REG_STATE:  prdata = {12'h000, state_q, conv_cnt_q, ~done_n_out, track,
			                       result_q};
			`REG_CTRL:   prdata = {23'h000000, clk_ext_q, ctrl_q};
			default:     prdata = 32'h00000000;
			endcase
		end
	end

endmodule

// ---- design/sar_seq_map.vh ----
// Purpose: Constants for the conversion sequencer: control byte fields, APB map, timing.
// Assumes: Included by bare name; definitions only.
// Notes:   Timing counts derive from the time in ns and the pclk rate in MHz.
`ifndef SAR_SEQ_MAP_VH
`define SAR_SEQ_MAP_VH

// Control byte field positions
`define CTRL_PD_HI       7
`define CTRL_PD_LO       6
`define CTRL_ACQ_BIT     5
`define CTRL_SGL_BIT     4
`define CTRL_UNI_BIT     3
`define CTRL_ADDR_HI     2
`define CTRL_ADDR_LO     0
`define CTRL_RESET       8'h00

// Power state field encodings
`define PWR_FULL_DOWN    2'h0
`define PWR_STANDBY      2'h1
`define PWR_NORMAL_INT   2'h2
`define PWR_NORMAL_EXT   2'h3

// Conversion timing, in conversion clock cycles
`define CONV_CYCLES      13
`define RESULT_BITS      10
`define ACQ_FALL_EDGES   4

// Internal acquisition time and pclk rate; one internal clock period is a quarter of it
`define INT_ACQ_NS       1000
`define PCLK_MHZ         200
`define INT_CLK_CYC      ((`INT_ACQ_NS * `PCLK_MHZ) / 1000 / `ACQ_FALL_EDGES)

// APB register byte offsets
`define REG_STATUS       12'h000
`define REG_MASK         12'h004
`define REG_STATE        12'h008
`define REG_CTRL         12'h00c

// Status bit positions
`define ST_DONE          0
`define ST_ABORT         1
`define ST_WRITE         2
`define ST_WIDTH         3
`define MASK_RESET       3'h0

`endif

// ---- tb/host_bus_model.sv ----
// Purpose: Host processor on the byte-wide port.
// Assumes: Strobes held well beyond the pin synchronisers.
// Notes:   Released data lines show the inverse of the last byte.
`timescale 1ns/10ps
module host_bus_model (
	input  wire       pclk,
	input  wire [7:0] data_out,
	output reg        cs_n,
	output reg        wr_n,
	output reg        rd_n,
	output reg        upper_byte_select,
	output reg  [7:0] data_in
);
	// Idle bus at time zero
	initial begin
		cs_n = 1'b1;
		wr_n = 1'b1;
		rd_n = 1'b1;
		upper_byte_select = 1'b0;
		data_in = 8'h00;
	end
	////////////////////////////////////////
	// Selected write; the rising strobe latches the byte
	task wr_byte(input [7:0] b);
		repeat (2) @(posedge pclk);
		cs_n <= 1'b0;
		wr_n <= 1'b0;
		data_in <= b;
		repeat (4) @(posedge pclk);
		wr_n <= 1'b1;
		repeat (4) @(posedge pclk);
		cs_n <= 1'b1;
		data_in <= ~b;
	endtask
	// Read cycle; u picks the result half
	task rd_byte(input u, output [7:0] d);
		repeat (2) @(posedge pclk);
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		upper_byte_select <= u;
		repeat (8) @(posedge pclk);
		d = data_out;
		cs_n <= 1'b1;
		rd_n <= 1'b1;
	endtask
endmodule

// ---- tb/sar_seq_properties.sv ----
// Purpose: Port checks of the conversion sequencer.
// Assumes: Conversion clock, internal or external, runs at INT_CLK_CYC pclk.
// Notes:   Pin strobes pass synchronisers, so windows allow a few pclk.
`timescale 1ns/10ps
module sar_seq_properties #(
	parameter INT_CLK_CYC = 8
) (
	input wire       pclk,
	input wire       presetn,
	input wire       cs_n,
	input wire       wr_n,
	input wire       upper_byte_select,
	input wire [7:0] data_in,
	input wire [7:0] data_out,
	input wire       done_n_out,
	input wire       track,
	input wire [2:0] mux_pos_sel,
	input wire [2:0] mux_neg_sel,
	input wire       neg_to_common,
	input wire [1:0] power_state_field
);
	localparam int HMIN = 3 * INT_CLK_CYC - 2;
	localparam int HMAX = 4 * INT_CLK_CYC + 2;
	localparam int CMIN = 12 * INT_CLK_CYC;
	localparam int CMAX = 14 * INT_CLK_CYC;
	reg       wr_n_q, trk_q, ext_q;
	reg [7:0] age_q, byte_q;
	reg [9:0] run_q;
	wire      wr_hit = wr_n && !wr_n_q && !cs_n;
	////////////////////////////////////////
	// Age and byte of the last selected write; length of the current phase of track, high or low
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_n_q <= 1'b1;
			trk_q  <= 1'b0;
			ext_q  <= 1'b0;
			age_q  <= 8'hff;
			byte_q <= 8'h00;
			run_q  <= 10'h000;
		end else begin
			wr_n_q <= wr_n;
			trk_q  <= track;
			age_q  <= wr_hit ? 8'h00 : age_q + {7'h00, age_q != 8'hff};
			byte_q <= wr_hit ? data_in : byte_q;
			ext_q  <= (track && !trk_q) ? byte_q[5] : ext_q;
			run_q  <= (track != trk_q) ? 10'h000 : run_q + {9'h000, run_q != 10'h3ff};
		end
	end
	////////////////////////////////////////
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	AST_TRACK_ON_WRITE: assert property ($rose(track) |-> age_q < 8)
		else $error("track rose without a write");
	AST_EXT_HOLD: assert property ($fell(track) && ext_q |-> age_q < 8)
		else $error("external hold without a write");
	AST_INT_HOLD: assert property ($fell(track) && !ext_q |-> run_q >= HMIN && run_q <= HMAX)
		else $error("internal acquisition length wrong");
	AST_CONV_LEN: assert property ($fell(done_n_out) |-> !track && run_q >= CMIN && run_q <= CMAX)
		else $error("conversion length wrong");
	AST_WRITE_RELEASES_DONE: assert property (wr_hit |-> ##[1:8] done_n_out)
		else $error("done not released by write");
	AST_UPPER_BYTE: assert property (upper_byte_select [*6] |-> data_out[7:2] == 6'h00)
		else $error("upper byte not two bits");
	AST_SINGLE_ENDED: assert property ($rose(track) && byte_q[4] |-> ##1 neg_to_common && mux_pos_sel == byte_q[2:0])
		else $error("single-ended routing wrong");
	AST_PSEUDO_DIFF: assert property ($rose(track) && !byte_q[4] |-> ##1 !neg_to_common && mux_neg_sel == (mux_pos_sel ^ 3'h1))
		else $error("pair routing wrong");
	AST_POWER_FIELD: assert property ($rose(track) |-> ##1 power_state_field == byte_q[7:6])
		else $error("power field wrong");
	cover property ($fell(done_n_out));
	cover property ($fell(track) && ext_q);
	cover property (upper_byte_select [*6]);
endmodule
bind sar_adc_conversion_sequencer sar_seq_properties #(.INT_CLK_CYC(INT_CLK_CYC))
	sar_seq_properties_inst (.pclk, .presetn, .cs_n, .wr_n, .upper_byte_select, .data_in,
	.data_out, .done_n_out, .track, .mux_pos_sel, .mux_neg_sel, .neg_to_common,
	.power_state_field);

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for the conversion sequencer.
// Assumes: Conversion clock shortened to 8 pclk.
// Notes:   Comparator models a fixed level, so each result is known.
`timescale 1ns/10ps
`include "sar_seq_map.vh"
module testbench;
	reg         pclk, presetn, psel, penable, pwrite, comparator_high, err, ext_clk;
	wire        done_n_oe;
	reg  [11:0] paddr;
	reg  [31:0] pwdata, rd;
	reg  [9:0]  tgt;
	wire [31:0] prdata;
	wire [7:0]  data_out, host_d, bus;
	wire [9:0]  dac_code;
	wire [2:0]  mux_pos_sel, mux_neg_sel;
	wire [1:0]  power_state_field;
	wire        pready, pslverr, irq, cs_n, wr_n, rd_n, upper_byte_select, data_oe;
	wire        done_n_out, track, neg_to_common, input_polarity_select;
	integer     n_fail = 0, total_checks = 0, i;
	reg  [7:0]  ctl_tab [0:3] = '{8'h9f, 8'h90, 8'h8a, 8'h85};
	reg  [9:0]  res_tab [0:3] = '{10'h3ff, 10'h000, 10'h2a5, 10'h15a};
	assign bus = data_oe ? data_out : host_d;
	sar_adc_conversion_sequencer #(.INT_CLK_CYC(8)) sar_adc_conversion_sequencer_inst (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .irq, .cs_n, .wr_n, .rd_n, .upper_byte_select, .data_in(bus), .data_out,
		.data_oe, .done_n_out, .done_n_oe, .ext_conv_clk(ext_clk), .comparator_high, .track,
		.dac_code, .mux_pos_sel, .mux_neg_sel, .neg_to_common, .input_polarity_select,
		.power_state_field);
	host_bus_model host_bus_model_inst (.pclk, .data_out, .cs_n, .wr_n, .rd_n,
		.upper_byte_select, .data_in(host_d));
	////////////////////////////////////////
	// Clock, comparator level and watchdog
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// External conversion clock, free running at the shortened internal rate
	initial begin
		ext_clk = 1'b0;
		forever #20 ext_clk = ~ext_clk;
	end
	always @(posedge pclk) comparator_high <= ({1'b0, dac_code} <= {1'b0, tgt});
	initial begin
		#200000;
		n_fail = n_fail + 1;
		conclude;
	end
	////////////////////////////////////////
	task chk(input string nm, input [31:0] e, input [31:0] g);
		total_checks = total_checks + 1;
		if (g !== e) begin
			n_fail = n_fail + 1;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One APB transfer; data and error taken at the completing edge
	task apb(input w, input [11:0] a, input [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Write a byte, wait for done, read both halves back
	task conv(input [7:0] c, input [9:0] t);
		reg [7:0] lo, hi;
		integer k;
		tgt = t;
		host_bus_model_inst.wr_byte(c);
		for (k = 0; k < 400 && done_n_out !== 1'b0; k = k + 1) @(posedge pclk);
		chk("done_n_out", 0, done_n_out);
		host_bus_model_inst.rd_byte(1'b0, lo);
		host_bus_model_inst.rd_byte(1'b1, hi);
		chk("result", t, {hi[1:0], lo});
		chk("upper", 0, hi[7:2]);
		chk("done release", 1, done_n_out);
	endtask
	task conclude;
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, tgt} = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 4; i = i + 1) begin
			conv(ctl_tab[i], res_tab[i]);
			chk("common", ctl_tab[i][4], neg_to_common);
			chk("pos", ctl_tab[i][2:0], mux_pos_sel);
			chk("polarity", ctl_tab[i][3], input_polarity_select);
			chk("power", 2, power_state_field);
		end
		// Masked event keeps irq low; unmasking shows it; a status read clears it
		apb(1'b0, `REG_STATUS, 0);
		conv(8'h9b, 10'h0f0);
		chk("irq masked", 0, irq);
		apb(1'b1, `REG_MASK, 1);
		chk("irq", 1, irq);
		apb(1'b0, `REG_STATUS, 0);
		chk("status", 5, rd[2:0]);
		chk("irq clear", 0, irq);
		// Externally timed acquisition tracks until the second write
		host_bus_model_inst.wr_byte(8'hbc);
		repeat (100) @(posedge pclk);
		chk("tracking", 1, track);
		conv(8'h9c, 10'h1c3);
		// A write in mid-conversion abandons it
		apb(1'b0, `REG_STATUS, 0);
		host_bus_model_inst.wr_byte(8'h9f);
		repeat (50) @(posedge pclk);
		chk("converting", 0, track);
		conv(8'h9f, 10'h055);
		apb(1'b0, `REG_STATUS, 0);
		chk("abort", 7, rd[2:0]);
		apb(1'b0, 12'h010, 0);
		chk("slverr", 1, err);
		// External conversion clock selected by the power field
		conv(8'hdf, 10'h2aa);
		chk("power ext", 3, power_state_field);
		apb(1'b0, `REG_CTRL, 0);
		chk("ctrl", 32'h000001df, rd);
		chk("done_oe", 0, done_n_oe);
		// Second reset in mid-run
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("track rst", 0, track);
		chk("done rst", 1, done_n_out);
		chk("common rst", 1, neg_to_common);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		// The block must work again after a mid-run reset, on the internal clock
		conv(8'h93, 10'h155);
		apb(1'b0, `REG_STATE, 0);
		chk("state", 32'h0001d155, rd);
		conclude;
	end
endmodule
